// file: rtl/thermo_pkg.sv
// Purpose: shared constants, carriers and helpers of the thermostat alarm block
// Assumes: 250 MHz system clock
// Notes:   register indices are word indices on the plain register port
`default_nettype none
package thermo_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;

  // maximum conversion time per precision setting, in ms
  localparam int unsigned CONV9_MS  = 25;
  localparam int unsigned CONV10_MS = 50;
  localparam int unsigned CONV11_MS = 100;
  localparam int unsigned CONV12_MS = 200;
  localparam int unsigned CONV_CW   = 26;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 2;

  localparam logic [1:0] ADDR_TEMP  = 2'h0;
  localparam logic [1:0] ADDR_CFG   = 2'h1;
  localparam logic [1:0] ADDR_LOWER = 2'h2;
  localparam logic [1:0] ADDR_UPPER = 2'h3;

  localparam logic [15:0] TEMP_RST      = 16'h0000;
  localparam logic [15:0] UPPER_RST     = 16'h5000;
  localparam logic [15:0] LOWER_RST     = 16'h4b00;
  localparam logic [15:0] LOW_NIBBLE_0  = 16'hfff0;
  localparam logic [7:0]  CFG_WMASK     = 8'h7f;

  typedef struct packed {
    logic reserved;
    logic precision_sel_hi;
    logic precision_sel_lo;
    logic fault_count_sel_hi;
    logic fault_count_sel_lo;
    logic alarm_polarity;
    logic alarm_behaviour_select;
    logic low_power_request;
  } cfg_t;

  localparam cfg_t CFG_RST = cfg_t'(8'h00);

  typedef enum logic {
    ST_RUN,
    ST_STANDBY
  } pwr_state_t;

  // keeps only the most significant bits that the precision setting uses
  function automatic logic [15:0] res_mask(input logic [1:0] prec);
    case (prec)
      2'h0:    res_mask = 16'hff80;
      2'h1:    res_mask = 16'hffc0;
      2'h2:    res_mask = 16'hffe0;
      default: res_mask = 16'hfff0;
    endcase
  endfunction

  // consecutive out-of-limit conversions needed to trigger
  function automatic logic [2:0] fault_target(input logic [1:0] fault_count_setting);
    case (fault_count_setting)
      2'h0:    fault_target = 3'h1;
      2'h1:    fault_target = 3'h2;
      2'h2:    fault_target = 3'h4;
      default: fault_target = 3'h6;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: rtl/bit_sync2.sv
// Purpose: two-flop synchroniser for inputs from outside the clock domain
// Assumes: multi-bit data is held stable around the sampling point
// Notes:   first stage is read only by the second stage
`default_nettype none
module bit_sync2 #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

// file: rtl/conv_timer.sv
// Purpose: paces conversions at the maximum conversion time of the precision
// Assumes: i_run low clears the count, so a resumed conversion starts afresh
// Notes:   o_done is a one-cycle pulse at the end of each conversion
`default_nettype none
module conv_timer
  import thermo_pkg::*;
#(
  parameter int unsigned CONV9_CYC  = CONV9_MS * CYC_PER_MS,
  parameter int unsigned CONV10_CYC = CONV10_MS * CYC_PER_MS,
  parameter int unsigned CONV11_CYC = CONV11_MS * CYC_PER_MS,
  parameter int unsigned CONV12_CYC = CONV12_MS * CYC_PER_MS
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_run,
  input  wire logic [1:0] i_prec,
  output logic            o_done
);
  logic [CONV_CW-1:0] cnt_ff;
  logic               done_ff;
  logic [CONV_CW-1:0] last_cnt;

  always_comb begin
    case (i_prec)
      2'h0:    last_cnt = CONV_CW'(CONV9_CYC - 1);
      2'h1:    last_cnt = CONV_CW'(CONV10_CYC - 1);
      2'h2:    last_cnt = CONV_CW'(CONV11_CYC - 1);
      default: last_cnt = CONV_CW'(CONV12_CYC - 1);
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_run) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (cnt_ff >= last_cnt) begin
      cnt_ff  <= '0;
      done_ff <= 1'b1;
    end else begin
      cnt_ff  <= CONV_CW'(cnt_ff + 1'b1);
      done_ff <= 1'b0;
    end
  end

  assign o_done = done_ff;
endmodule
`default_nettype wire

// file: rtl/thermo_alarm.sv
// Purpose: thermostat alarm control with trip points, fault count and shutdown
// Assumes: ADC result on I_ADC_DATA is stable while a conversion ends
// Notes:   alarm pin is open drain, modelled as value and enable
// Function
// - low-power request finishes current conversion, stores result, then enters standby.
// - entering standby clears alarm in interrupt behaviour, keeps it in comparator.
// - register port works in standby; writing zero to request resumes conversions.
// - reset gives comparator, active-low alarm, upper 80 C, lower 75 C.
// - alarm triggers after 1, 2, 4 or 6 consecutive out-of-limit results.
// - trip points use temperature format, low four bits always zero.
// - each completed conversion is compared with the trip points, alarm updated except while an interrupt alarm is set or at interrupt standby entry.
// - comparison uses only the most significant bits of the selected precision.
// - alarm active level follows polarity bit, active low after reset.
// - comparator behaviour asserts after enough consecutive results above upper trip.
// - comparator alarm holds until a result below lower trip; standby keeps it.
// - interrupt behaviour first asserts after enough consecutive results above upper.
// - interrupt alarm clears only on standby entry, any register read or a behaviour-bit change.
// - after a clear, interrupt alarm waits for the opposite trip event.
// - configuration read/write except top bit, which reads zero; reset defaults.
// - trip-point registers keep written values with low four bits cleared, as plain storage.
// - fault field 00,01,10,11 means 1,2,4,6 conversions.
// - polarity 0 gives active-low alarm, 1 active-high.
// - behaviour bit 0 is comparator, 1 is interrupt; reset value 0.
// - precision field selects 9 to 12 bits with 25 to 200 ms conversion.
`default_nettype none
module thermo_alarm
  import thermo_pkg::*;
#(
  parameter int unsigned CONV9_CYC  = CONV9_MS * CYC_PER_MS,
  parameter int unsigned CONV10_CYC = CONV10_MS * CYC_PER_MS,
  parameter int unsigned CONV11_CYC = CONV11_MS * CYC_PER_MS,
  parameter int unsigned CONV12_CYC = CONV12_MS * CYC_PER_MS
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_NRST,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  input  wire logic [DATA_W-1:0] I_ADC_DATA,
  output logic      [DATA_W-1:0] O_RDATA,
  output logic                   O_ALARM_O,
  output logic                   O_ALARM_OE,
  output logic                   O_ALARM_ACTIVE,
  output logic                   O_STANDBY
);
  cfg_t              cfg_ff;
  logic [15:0]       upper_trip_point_ff;
  logic [15:0]       lower_trip_point_ff;
  logic [15:0]       temp_ff;
  logic [15:0]       rdata_ff;
  pwr_state_t        state_ff;
  logic              standby_ff;
  logic              alarm_ff;
  logic              expect_low_ff;
  logic [2:0]        cnt_ff;
  logic              oe_ff;
  logic              drive_ff;
  logic [15:0]       adc_q;
  logic              conv_done;
  logic [1:0]        prec;
  logic [1:0]        fault_count_setting;
  logic [15:0]       mask;
  logic [15:0]       new_temp;
  logic              above;
  logic              below;
  logic              watch;
  logic [2:0]        target;
  logic [2:0]        cnt_inc;
  logic              hit;
  logic              standby_entry;
  logic              mode_chg;
  logic              intr_mode;
  cfg_t              wr_cfg;

  bit_sync2 #(
    .W (DATA_W)
  ) u_adc_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_ADC_DATA),
    .o_sync  (adc_q)
  );

  // conversion pacing stops while in standby
  conv_timer #(
    .CONV9_CYC  (CONV9_CYC),
    .CONV10_CYC (CONV10_CYC),
    .CONV11_CYC (CONV11_CYC),
    .CONV12_CYC (CONV12_CYC)
  ) u_timer (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_run  (state_ff == ST_RUN),
    .i_prec (prec),
    .o_done (conv_done)
  );

  assign prec                = {cfg_ff.precision_sel_hi, cfg_ff.precision_sel_lo};
  assign fault_count_setting = {cfg_ff.fault_count_sel_hi, cfg_ff.fault_count_sel_lo};
  assign intr_mode           = cfg_ff.alarm_behaviour_select;
  assign mask                = res_mask(prec);
  assign new_temp            = adc_q & mask;
  // signed compare on the bits that the precision keeps
  assign above    = $signed(new_temp) > $signed(upper_trip_point_ff & mask);
  assign below    = $signed(new_temp) < $signed(lower_trip_point_ff & mask);
  assign watch    = intr_mode ? (expect_low_ff ? below : above) : above;
  assign target   = fault_target(fault_count_setting);
  assign cnt_inc  = 3'(cnt_ff + 3'h1);
  // at or beyond the target, so a lowered fault setting cannot be overrun
  assign hit      = watch && (cnt_inc >= target);
  assign standby_entry = conv_done && cfg_ff.low_power_request && (state_ff == ST_RUN);
  assign wr_cfg   = cfg_t'(I_WDATA[7:0] & CFG_WMASK);
  assign mode_chg = I_WR && (I_ADDR == ADDR_CFG) &&
                    (wr_cfg.alarm_behaviour_select != cfg_ff.alarm_behaviour_select);

  // configuration and trip-point registers
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      cfg_ff              <= CFG_RST;
      upper_trip_point_ff <= UPPER_RST;
      lower_trip_point_ff <= LOWER_RST;
    end else if (I_WR) begin
      case (I_ADDR)
        ADDR_CFG:   cfg_ff <= cfg_t'(I_WDATA[7:0] & CFG_WMASK);
        ADDR_LOWER: lower_trip_point_ff <= I_WDATA & LOW_NIBBLE_0;
        ADDR_UPPER: upper_trip_point_ff <= I_WDATA & LOW_NIBBLE_0;
        default:    cfg_ff <= cfg_ff;
      endcase
    end
  end

  // temperature register catches every completed conversion
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      temp_ff <= TEMP_RST;
    end else if (conv_done) begin
      temp_ff <= new_temp;
    end
  end

  // power state: standby only after a conversion has completed
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      state_ff   <= ST_RUN;
      standby_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (standby_entry) begin
            state_ff   <= ST_STANDBY;
            standby_ff <= 1'b1;
          end
        end
        ST_STANDBY: begin
          if (!cfg_ff.low_power_request) begin
            state_ff   <= ST_RUN;
            standby_ff <= 1'b0;
          end
        end
        default: begin
          state_ff   <= ST_RUN;
          standby_ff <= 1'b0;
        end
      endcase
    end
  end

  // alarm state, fault counter and expected interrupt event
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      alarm_ff      <= 1'b0;
      cnt_ff        <= 3'h0;
      expect_low_ff <= 1'b0;
    end else if (mode_chg) begin
      alarm_ff      <= 1'b0;
      cnt_ff        <= 3'h0;
      expect_low_ff <= 1'b0;
    end else if (standby_entry && intr_mode) begin
      alarm_ff <= 1'b0;
      cnt_ff   <= 3'h0;
    end else if (intr_mode) begin
      if (conv_done && !alarm_ff && hit) begin
        alarm_ff      <= 1'b1;
        expect_low_ff <= !expect_low_ff;
        cnt_ff        <= 3'h0;
      end else if (conv_done && !alarm_ff && watch) begin
        cnt_ff <= cnt_inc;
      end else if (conv_done && !alarm_ff) begin
        cnt_ff <= 3'h0;
      end else if (I_RD && alarm_ff) begin
        alarm_ff <= 1'b0;
        cnt_ff   <= 3'h0;
      end
    end else if (conv_done) begin
      if (alarm_ff) begin
        if (below) begin
          alarm_ff <= 1'b0;
        end
        cnt_ff <= 3'h0;
      end else if (hit) begin
        alarm_ff <= 1'b1;
        cnt_ff   <= 3'h0;
      end else if (watch) begin
        cnt_ff <= cnt_inc;
      end else begin
        cnt_ff <= 3'h0;
      end
    end
  end

  // open-drain pin: enable pulls low, so it is on when the level should be low
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      oe_ff    <= 1'b0;
      drive_ff <= 1'b0;
    end else begin
      oe_ff    <= alarm_ff ^ cfg_ff.alarm_polarity;
      drive_ff <= 1'b0;
    end
  end

  // read data valid in the cycle after the read strobe only
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      rdata_ff <= '0;
    end else if (I_RD) begin
      case (I_ADDR)
        ADDR_TEMP:  rdata_ff <= temp_ff;
        ADDR_CFG:   rdata_ff <= {8'h00, 8'(cfg_ff) & CFG_WMASK};
        ADDR_LOWER: rdata_ff <= lower_trip_point_ff;
        default:    rdata_ff <= upper_trip_point_ff;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign O_RDATA        = rdata_ff;
  assign O_ALARM_O      = drive_ff;
  assign O_ALARM_OE     = oe_ff;
  assign O_ALARM_ACTIVE = alarm_ff;
  assign O_STANDBY      = standby_ff;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_NRST);

  property p_standby_after_done;
    $rose(standby_ff) |-> $past(conv_done) && $past(cfg_ff.low_power_request);
  endproperty
  a_standby_after_done: assert property (p_standby_after_done)
    else $error("standby entered without a completed conversion");

  property p_int_clear_on_standby;
    standby_entry && intr_mode && !mode_chg |=> !alarm_ff && standby_ff;
  endproperty
  a_int_clear_on_standby: assert property (p_int_clear_on_standby)
    else $error("interrupt alarm not cleared on standby entry");

  property p_cmp_hold_in_standby;
    standby_ff && !intr_mode && !mode_chg |=> alarm_ff == $past(alarm_ff);
  endproperty
  a_cmp_hold_in_standby: assert property (p_cmp_hold_in_standby)
    else $error("comparator alarm changed during standby");

  property p_resume;
    standby_ff && !cfg_ff.low_power_request |=> !standby_ff ##1 !standby_ff;
  endproperty
  a_resume: assert property (p_resume)
    else $error("standby not left after request cleared");

  property p_trip_format;
    (upper_trip_point_ff[3:0] == 4'h0) && (lower_trip_point_ff[3:0] == 4'h0);
  endproperty
  a_trip_format: assert property (p_trip_format)
    else $error("trip point low bits not zero");

  property p_rise_cause;
    $rose(alarm_ff) |-> $past(conv_done) && ($past(cnt_inc) >= $past(target));
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("alarm rose without the full fault count");

  property p_int_read_clear;
    intr_mode && alarm_ff && I_RD && !conv_done && !mode_chg |=>
      !alarm_ff ##1 (O_ALARM_OE == $past(cfg_ff.alarm_polarity));
  endproperty
  a_int_read_clear: assert property (p_int_read_clear)
    else $error("interrupt alarm not cleared by a read");

  property p_cmp_drop;
    !intr_mode && alarm_ff && conv_done && below && !mode_chg |=> !alarm_ff;
  endproperty
  a_cmp_drop: assert property (p_cmp_drop)
    else $error("comparator alarm kept after result below lower trip");

  property p_pin_level;
    ##1 O_ALARM_OE == ($past(alarm_ff) ^ $past(cfg_ff.alarm_polarity));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("alarm pin level does not follow polarity");

  property p_cfg_top_zero;
    I_RD && (I_ADDR == ADDR_CFG) |=> O_RDATA[15:7] == 9'h000;
  endproperty
  a_cfg_top_zero: assert property (p_cfg_top_zero)
    else $error("reserved configuration bits read non-zero");

  // counter, hold, storage and standby checks
  property p_cnt_restart;
    conv_done && !alarm_ff && !watch |=> cnt_ff == 3'h0;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart)
    else $error("fault count kept after a non-qualifying result");

  property p_int_hold;
    intr_mode && alarm_ff && !I_RD && !standby_entry && !mode_chg |=> alarm_ff;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt alarm cleared without a read or standby entry");

  property p_temp_store;
    conv_done |=> temp_ff == $past(new_temp);
  endproperty
  a_temp_store: assert property (p_temp_store)
    else $error("completed conversion not stored");

  property p_standby_quiet;
    standby_ff |-> !conv_done;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("conversion completed during standby");

  c_cmp_alarm: cover property (!intr_mode && $rose(alarm_ff));
  c_int_low_event: cover property (intr_mode && expect_low_ff && $fell(alarm_ff));
  c_standby: cover property ($rose(standby_ff) ##[1:20] $fell(standby_ff));
  c_read_clear: cover property (intr_mode && alarm_ff && I_RD);
  c_cmp_standby: cover property (!intr_mode && alarm_ff && $rose(standby_ff));
endmodule
`default_nettype wire

// file: verification/reg_master.sv
// Purpose: register-port master standing in for the serial bus host
// Assumes: strobes launch right after a rising edge and last one cycle
// Notes:   read data is taken only in the cycle after the strobe
`default_nettype none
module reg_master
  import thermo_pkg::*;
(
  input  wire logic              i_clk,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata,
  output logic                   o_wr,
  output logic                   o_rd,
  input  wire logic [DATA_W-1:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    // released data no longer shows the written word
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/thermo_alarm_tb.sv
// Purpose: self-checking bench of the thermostat alarm block
// Assumes: shortened conversion lengths of 40, 60, 80 and 100 clocks
// Notes:   conversion phase is realigned by a standby round trip
`default_nettype none
module thermo_alarm_tb
  import thermo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              nrst;
  logic [DATA_W-1:0] adc;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              alarm_o;
  logic              alarm_oe;
  logic              alarm_act;
  logic              standby;
  int                err_count;
  int                check_count;
  int                tgt;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  thermo_alarm #(.CONV9_CYC(40), .CONV10_CYC(60), .CONV11_CYC(80), .CONV12_CYC(100)) uut (
    .I_SYS_CLK      (clk),
    .I_NRST         (nrst),
    .I_ADDR         (addr),
    .I_WDATA        (wdata),
    .I_WR           (wr),
    .I_RD           (rd),
    .I_ADC_DATA     (adc),
    .O_RDATA        (rdata),
    .O_ALARM_O      (alarm_o),
    .O_ALARM_OE     (alarm_oe),
    .O_ALARM_ACTIVE (alarm_act),
    .O_STANDBY      (standby)
  );

  reg_master m (
    .i_clk   (clk),
    .o_addr  (addr),
    .o_wdata (wdata),
    .o_wr    (wr),
    .o_rd    (rd),
    .i_rdata (rdata)
  );

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [1:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    m.rd(a, d);
    chk16(what, exp, d);
  endtask

  task automatic setadc(input logic [15:0] v);
    @(posedge clk);
    adc <= v;
  endtask

  task automatic waitc(input int k, input int p);
    repeat (k * p) @(posedge clk);
    #1;
  endtask

  task automatic wait_sb(input logic v);
    int n;
    n = 0;
    while (standby !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1("standby", v, standby);
  endtask

  // standby round trip so the next conversion ends a known time later
  task automatic resync(input logic [7:0] c);
    m.wr(ADDR_CFG, {8'h00, c | 8'h01});
    wait_sb(1'b1);
    m.wr(ADDR_CFG, {8'h00, c});
    wait_sb(1'b0);
    repeat (20) @(posedge clk);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    err_count   = 0;
    check_count = 0;
    nrst        = 1'b0;
    adc         = 16'h4d00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdchk(ADDR_TEMP, 16'h0000, "temp reset");
    rdchk(ADDR_CFG, 16'h0000, "cfg reset");
    rdchk(ADDR_UPPER, 16'h5000, "upper reset");
    rdchk(ADDR_LOWER, 16'h4b00, "lower reset");
    chk1("pin enable reset", 1'b0, alarm_oe);
    chk1("pin value", 1'b0, alarm_o);
    m.wr(ADDR_CFG, 16'h00fe);
    rdchk(ADDR_CFG, 16'h007e, "cfg top bit");
    m.wr(ADDR_LOWER, 16'h1234);
    rdchk(ADDR_LOWER, 16'h1230, "lower store");
    m.wr(ADDR_UPPER, 16'hfedf);
    rdchk(ADDR_UPPER, 16'hfed0, "upper store");
    m.wr(ADDR_UPPER, 16'h5000);
    m.wr(ADDR_LOWER, 16'h4b00);
    m.wr(ADDR_CFG, 16'h0000);
    // comparator behaviour, every fault count setting
    for (int f = 0; f < 4; f++) begin
      tgt = (f == 3) ? 6 : (1 << f);
      setadc(16'h4d00);
      resync(8'(f << 3));
      setadc(16'h5100);
      waitc(tgt - 1, 40);
      chk1("alarm early", 1'b0, alarm_act);
      waitc(1, 40);
      chk1("alarm at count", 1'b1, alarm_act);
      chk1("pin low active", 1'b1, alarm_oe);
      setadc(16'h4d00);
      resync(8'(f << 3));
      chk1("comparator standby keeps", 1'b1, alarm_act);
      setadc(16'h4a00);
      waitc(1, 40);
      chk1("alarm drop", 1'b0, alarm_act);
    end
    // a non-qualifying result in between restarts the count
    resync(8'h08);
    setadc(16'h5100);
    waitc(1, 40);
    setadc(16'h4d00);
    waitc(1, 40);
    setadc(16'h5100);
    waitc(1, 40);
    chk1("count restart", 1'b0, alarm_act);
    m.wr(ADDR_CFG, 16'h0004);
    waitc(1, 2);
    chk1("pin high idle", 1'b1, alarm_oe);
    setadc(16'h5100);
    waitc(2, 40);
    chk1("pin high active", 1'b0, alarm_oe);
    // precision codes: only the selected top bits take part
    for (int p = 0; p < 4; p++) begin
      m.wr(ADDR_CFG, {8'h00, 8'(p << 5)});
      setadc(16'h4a00);
      waitc(2, 40 + 20 * p);
      setadc(16'h5000 + (16'h0040 >> p));
      waitc(2, 40 + 20 * p);
      chk1("below precision", 1'b0, alarm_act);
      setadc(16'h5000 + (16'h0080 >> p));
      waitc(2, 40 + 20 * p);
      chk1("at precision", 1'b1, alarm_act);
      rdchk(ADDR_TEMP, 16'h5000 + (16'h0080 >> p), "temp masked");
    end
    // interrupt behaviour, fault count two
    setadc(16'h4d00);
    m.wr(ADDR_CFG, 16'h000a);
    resync(8'h0a);
    setadc(16'h5100);
    waitc(1, 40);
    chk1("int early", 1'b0, alarm_act);
    waitc(1, 40);
    chk1("int upper", 1'b1, alarm_act);
    rdchk(ADDR_CFG, 16'h000a, "cfg read");
    waitc(1, 2);
    chk1("read clear", 1'b0, alarm_act);
    waitc(3, 40);
    chk1("no repeat upper", 1'b0, alarm_act);
    setadc(16'h4a00);
    waitc(3, 40);
    chk1("int lower", 1'b1, alarm_act);
    rdchk(ADDR_LOWER, 16'h4b00, "lower read");
    setadc(16'h5100);
    waitc(3, 40);
    chk1("int upper again", 1'b1, alarm_act);
    m.wr(ADDR_CFG, 16'h000b);
    wait_sb(1'b1);
    chk1("standby clears", 1'b0, alarm_act);
    m.wr(ADDR_TEMP, 16'h1230);
    setadc(16'h4000);
    waitc(3, 40);
    rdchk(ADDR_TEMP, 16'h5100, "temp frozen");
    m.wr(ADDR_CFG, 16'h000a);
    wait_sb(1'b0);
    waitc(3, 40);
    chk1("resumed lower", 1'b1, alarm_act);
    rdchk(ADDR_TEMP, 16'h4000, "temp resumed");
    // a reset in mid-run brings back the power-up settings
    m.wr(ADDR_UPPER, 16'h6000);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdchk(ADDR_CFG, 16'h0000, "cfg after reset");
    rdchk(ADDR_UPPER, 16'h5000, "upper after reset");
    chk1("alarm after reset", 1'b0, alarm_act);
    chk1("pin after reset", 1'b0, alarm_oe);
    wrap_up();
  end
endmodule
`default_nettype wire
